//--- hw/fsr_pkg.sv
// Package: opcodes, bit positions, reset values and timing for status regs
package fsr_pkg;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_SECOND_A = 8'h09;
  localparam logic [7:0] OP_READ_SECOND_B = 8'h35;
  localparam logic [7:0] OP_READ_THIRD_A = 8'h95;
  localparam logic [7:0] OP_READ_THIRD_B = 8'h15;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam int S2_ERASE_SUSP = 7;
  localparam int S2_COMPLEMENT = 6;
  localparam int S2_LOCK_FIRST = 5;
  localparam int S2_LOCK_THIRD = 3;
  localparam int S2_PROG_SUSP = 2;
  localparam int S2_QUAD_SEL = 1;
  localparam int S3_HOLD_RESET = 7;
  localparam logic [7:0] FIRST_RESET = 8'h00;
  localparam logic [7:0] SECOND_RESET = 8'h02;
  localparam logic [7:0] THIRD_RESET = 8'h00;
  localparam logic [7:0] FIRST_WR_MASK = 8'hFC;
  localparam logic [7:0] THIRD_WR_MASK = 8'hF8;
  localparam int CLK_MHZ = 50;
  localparam int WRITE_CYCLE_US = 5;
  localparam int WRITE_CYCLES = WRITE_CYCLE_US * CLK_MHZ;
  localparam logic [5:0] BITS_ONE = 6'd8;
  localparam logic [5:0] BITS_TWO = 6'd16;
  localparam logic [5:0] BITS_THREE = 6'd24;
  typedef enum logic [1:0] {FSR_OPCODE, FSR_DATA, FSR_IGNORE} fsr_phase_t;
  typedef struct packed {
    logic erase_susp;
    logic prog_susp;
    logic [2:0] locks;
    logic complement_protect;
    logic quad_pin_select;
    logic hold_reset_select;
    logic [1:0] drive;
    logic [1:0] wrap_len;
  } fsr_cfg_t;
endpackage : fsr_pkg

//--- hw/fsr_status_regs.sv
// Second and third status registers of a serial flash with write path
// How it works
// RQ1: Erase-suspended flag bit 7 sets on erase suspend, clears on resume.
// RQ2: Program-suspended flag bit 2 sets on program suspend, clears on resume.
// RQ3: Both suspend flags are zero after reset.
// RQ4: Lock bits 5..3 at one block program and erase of their sector.
// RQ5: Lock bits are one-time programmable; once one they never clear.
// RQ6: A lock bit at zero leaves its sector fully usable.
// RQ7: Complement-protect bit 6 resets to zero and once one stays one.
// RQ8: Quad pin select bit 1 resets to one; zero enables pin functions.
// RQ9: Bit 0 of the second register always reads zero.
// RQ10: Host should mask the reserved bit when testing the register.
// RQ11: Read-third opcodes return third register anytime, repeating while selected.
// RQ12: Hold/reset select bit 7 picks pause at zero, reset at one.
// RQ13: Pin pause/reset acts only while quad pin select is zero.
// RQ14: Bits 6..5 select drive strength: 67, 100, 50, 33 percent.
// RQ15: Bits 4..3 select wrap length: 8, 16, 32, 64 bytes.
// RQ16: Bits 2..0 of the third register are reserved, no function.
// RQ17: Write-status is accepted only while the write latch is one.
// RQ18: Write-status is executed only if select rises after 8, 16 or 24 bits.
// RQ19: Valid write-status starts a timed cycle; busy flag one throughout.
// RQ20: The write latch clears when the write cycle completes.
// RQ21: Write-status never changes the write latch or busy bits directly.
// RQ22: Status protect with protect pin low rejects every write-status.
// RQ23: Data bytes go to first, second, third register in order.
`timescale 1ns/1ps
`default_nettype none
module fsr_status_regs
  import fsr_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_DI,
  input wire logic I_WP_N,
  input wire logic I_HOLD_RESET_N,
  input wire logic I_ERASE_ACTIVE,
  input wire logic I_PROG_ACTIVE,
  output logic O_DO,
  output logic O_DO_OE,
  output logic [7:0] O_FIRST_STATUS,
  output logic [7:0] O_SECOND_STATUS,
  output logic [7:0] O_THIRD_STATUS,
  output logic [2:0] O_SECTOR_LOCKED,
  output logic O_PAUSE,
  output logic O_PIN_RESET,
  output logic [1:0] O_DRIVE,
  output logic [1:0] O_WRAP
);
  logic [1:0] sclk_s, cs_s, di_s, wp_s, hr_s;
  logic sclk_d, cs_d;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      di_s <= 2'h0;
      wp_s <= 2'h3;
      hr_s <= 2'h3;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], I_SCLK};
      cs_s <= {cs_s[0], I_CS_N};
      di_s <= {di_s[0], I_DI};
      wp_s <= {wp_s[0], I_WP_N};
      hr_s <= {hr_s[0], I_HOLD_RESET_N};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end
  wire sel = !cs_s[1];
  wire rise = sel && sclk_s[1] && !sclk_d;
  wire fall = sel && !sclk_s[1] && sclk_d;
  wire cs_rise = cs_s[1] && !cs_d;

  fsr_phase_t phase;
  logic [7:0] shift, opcode, first, second, third;
  logic [7:0] d1, d2, d3, out_sh;
  logic [5:0] bits;
  logic [2:0] bitc;
  logic latch, busy, e_susp, p_susp;
  logic [15:0] timer;
  wire [2:0] next_bitc = bitc + 3'h1;
  wire [7:0] next_byte = {shift[6:0], di_s[1]};
  wire hw_lock = first[7] && !wp_s[1];
  wire [7:0] first_view = {first[7:2], latch, busy};
  wire [7:0] second_view = {e_susp, second[6:3], p_susp, second[1],
    1'b0}; // [RQ9]

  function automatic logic [7:0] read_word(input logic [7:0] op,
    input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3);
    if (op == OP_READ_THIRD_A || op == OP_READ_THIRD_B)
      return w3; // [RQ11]
    else if (op == OP_READ_SECOND_A || op == OP_READ_SECOND_B)
      return w2; // [RQ1] [RQ2]
    else
      return w1;
  endfunction : read_word
  wire [7:0] out_word = read_word(opcode, first_view, second_view, third);

  // Serial shifter and command decode
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase <= FSR_OPCODE;
      shift <= 8'h00;
      opcode <= 8'h00;
      bitc <= 3'h0;
      bits <= 6'h00;
      d1 <= 8'h00;
      d2 <= 8'h00;
      d3 <= 8'h00;
    end else if (!sel) begin
      phase <= FSR_OPCODE;
      bitc <= 3'h0;
      bits <= 6'h00;
      opcode <= cs_rise ? opcode : 8'h00;
    end else if (rise) begin
      shift <= next_byte;
      bitc <= next_bitc;
      if (phase == FSR_DATA) begin
        if (bits != 6'h3F)
          bits <= bits + 6'h01;
        if (bitc == 3'h7) begin
          unique case (bits[5:3])
            3'h0: d1 <= next_byte; // [RQ23]
            3'h1: d2 <= next_byte; // [RQ23]
            3'h2: d3 <= next_byte; // [RQ23]
            default: ;
          endcase
        end
      end else if (phase == FSR_OPCODE && bitc == 3'h7) begin
        opcode <= next_byte;
        phase <= (next_byte == OP_WRITE_STATUS) ? FSR_DATA : FSR_IGNORE;
      end
    end
  end

  wire bits_ok = bits == BITS_ONE || bits == BITS_TWO || bits == BITS_THREE;
  wire wr_go = cs_rise && opcode == OP_WRITE_STATUS && bits_ok // [RQ18]
      && latch && !busy && !hw_lock; // [RQ17] [RQ22]
  wire op_done = cs_rise && bits == 6'h00;

  // Write latch, busy flag and timed write cycle
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      latch <= 1'b0;
      busy <= 1'b0;
      timer <= 16'h0000;
    end else if (busy) begin
      if (timer == 16'(WRITE_CYCLES - 1)) begin
        busy <= 1'b0; // [RQ19]
        latch <= 1'b0; // [RQ20]
      end
      timer <= timer + 16'h0001;
    end else if (wr_go) begin
      busy <= 1'b1; // [RQ19]
      timer <= 16'h0000;
    end else if (op_done && opcode == OP_WRITE_LATCH_SET) begin
      latch <= 1'b1;
    end else if (op_done && opcode == OP_WRITE_LATCH_CLR) begin
      latch <= 1'b0;
    end
  end

  // Status register contents, committed at start of the write cycle
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      first <= FIRST_RESET;
      second <= SECOND_RESET;
      third <= THIRD_RESET;
    end else if (wr_go) begin
      first <= d1 & FIRST_WR_MASK; // [RQ21]
      if (bits != BITS_ONE) begin
        second[S2_LOCK_FIRST:S2_LOCK_THIRD] <=
          second[S2_LOCK_FIRST:S2_LOCK_THIRD]
          | d2[S2_LOCK_FIRST:S2_LOCK_THIRD]; // [RQ5]
        second[S2_COMPLEMENT] <= second[S2_COMPLEMENT]
          | d2[S2_COMPLEMENT]; // [RQ7]
        second[S2_QUAD_SEL] <= d2[S2_QUAD_SEL]; // [RQ8]
      end
      if (bits == BITS_THREE)
        third <= d3 & THIRD_WR_MASK; // [RQ16]
    end
  end

  // Suspend indicators
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      e_susp <= 1'b0; // [RQ3]
      p_susp <= 1'b0; // [RQ3]
    end else if (op_done && opcode == OP_SUSPEND) begin
      e_susp <= e_susp | I_ERASE_ACTIVE; // [RQ1]
      p_susp <= p_susp | I_PROG_ACTIVE; // [RQ2]
    end else if (op_done && opcode == OP_RESUME) begin
      e_susp <= 1'b0; // [RQ1]
      p_susp <= 1'b0; // [RQ2]
    end
  end

  // Serial output, repeating the selected register while selected
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      out_sh <= 8'h00;
      O_DO <= 1'b0;
      O_DO_OE <= 1'b0;
    end else if (!sel) begin
      O_DO_OE <= 1'b0;
    end else if (fall && phase == FSR_IGNORE) begin
      if (bitc == 3'h0) begin
        O_DO <= out_word[7]; // [RQ11]
        out_sh <= {out_word[6:0], 1'b0};
      end else begin
        O_DO <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
      O_DO_OE <= 1'b1;
    end
  end

  // Register views and pin functions
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FIRST_STATUS <= 8'h00;
      O_SECOND_STATUS <= 8'h00;
      O_THIRD_STATUS <= 8'h00;
      O_SECTOR_LOCKED <= 3'h0;
      O_PAUSE <= 1'b0;
      O_PIN_RESET <= 1'b0;
      O_DRIVE <= 2'h0;
      O_WRAP <= 2'h0;
    end else begin
      O_FIRST_STATUS <= first_view;
      O_SECOND_STATUS <= second_view; // [RQ9]
      O_THIRD_STATUS <= third;
      O_SECTOR_LOCKED <= second[S2_LOCK_FIRST:S2_LOCK_THIRD]; // [RQ4] [RQ6]
      O_PAUSE <= !second[S2_QUAD_SEL] && !third[S3_HOLD_RESET]
        && !hr_s[1]; // [RQ12] [RQ13]
      O_PIN_RESET <= !second[S2_QUAD_SEL] && third[S3_HOLD_RESET]
        && !hr_s[1]; // [RQ12] [RQ13]
      O_DRIVE <= third[6:5]; // [RQ14]
      O_WRAP <= third[4:3]; // [RQ15]
    end
  end

  a_lock_sticky: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $fell(second[S2_LOCK_FIRST]) == 1'b0) // [RQ5]
    else $error("lock bit cleared");
  a_cmp_sticky: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !$fell(second[S2_COMPLEMENT])) // [RQ7]
    else $error("complement bit cleared");
  a_reserved_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_SECOND_STATUS[0] == 1'b0) // [RQ9]
    else $error("reserved bit set");
  a_go_needs_latch: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) $rose(busy) |-> $past(latch)) // [RQ17]
    else $error("write without latch");
  a_go_not_locked: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) $rose(busy) |-> !$past(hw_lock)) // [RQ22]
    else $error("write in locked mode");
  a_go_bit_count: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) $rose(busy) |-> $past(bits_ok)) // [RQ18]
    else $error("bad bit count accepted");
  a_busy_length: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) $rose(busy) |-> busy [*8]) // [RQ19]
    else $error("busy too short");
  a_latch_clear: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) $fell(busy) |-> !latch) // [RQ20]
    else $error("latch kept after write");
  a_pin_quad: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $past(second[S2_QUAD_SEL]) |-> !O_PAUSE && !O_PIN_RESET) // [RQ13]
    else $error("pin function with quad select");
  a_locks_kept: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    ($past(second[S2_LOCK_FIRST:S2_LOCK_THIRD])
    & ~second[S2_LOCK_FIRST:S2_LOCK_THIRD]) == 3'h0) // [RQ5]
    else $error("a lock bit cleared");
  a_busy_cycles: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $fell(busy) |-> $past(timer) == 16'(WRITE_CYCLES - 1)) // [RQ19]
    else $error("write cycle length wrong");
  a_go_keeps_latch: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) wr_go |=> latch == $past(latch)) // [RQ21]
    else $error("write start changed latch");
  a_resume_clears: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) op_done && opcode == OP_RESUME
    |=> !e_susp && !p_susp) // [RQ1] [RQ2]
    else $error("suspend flag kept after resume");
  a_third_reserved: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) O_THIRD_STATUS[2:0] == 3'h0) // [RQ16]
    else $error("reserved third bits set");
  a_drive_view: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_DRIVE == $past(third[6:5]) && O_WRAP == $past(third[4:3])) // [RQ14]
    else $error("drive or wrap code mismatch");
  a_sector_view: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_SECTOR_LOCKED == $past(second[S2_LOCK_FIRST:S2_LOCK_THIRD])) // [RQ4]
    else $error("sector lock view mismatch");
  a_read_reload: assert property (@(posedge I_REF_CLK)
    disable iff (!I_RST_N) fall && phase == FSR_IGNORE && bitc == 3'h0
    |=> O_DO == $past(out_word[7]) && O_DO_OE) // [RQ11]
    else $error("read word not reloaded");
  c_write_go: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(busy));
  c_three_bytes: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    wr_go && bits == BITS_THREE);
  c_suspend: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(e_susp));
  c_read_third: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    fall && phase == FSR_IGNORE && opcode == OP_READ_THIRD_A);
endmodule : fsr_status_regs
`default_nettype wire

//--- verification/fsr_spi_host.sv
// SPI host model: mode 0 frames, clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module fsr_spi_host (
  input wire logic i_clk,
  input wire logic i_do,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_di
);
  logic [15:0] rx;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_di = 1'b0;
    rx = 16'h0000;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wait_clk
  // Sends the top nbits of data MSB first, keeps bits seen after bit 8
  task automatic frame(input logic [31:0] data, input int nbits);
    wait_clk(1);
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_di = data[31 - i];
      wait_clk(4);
      o_sclk = 1'b1;
      wait_clk(4);
      if (i >= 8) rx = {rx[14:0], i_do};
      o_sclk = 1'b0;
    end
    wait_clk(4);
    o_cs_n = 1'b1;
    o_di = ~o_di;
    wait_clk(8);
  endtask : frame
endmodule : fsr_spi_host
`default_nettype wire

//--- verification/tb_fsr_status_regs.sv
// Testbench for the second and third status registers and write path
`timescale 1ns/1ps
`default_nettype none
module tb_fsr_status_regs;
  import fsr_pkg::*;
  logic clk, rst_n, wp_n, hr_n, er, pr, dout, doe, ps, prst;
  wire logic sclk, cs_n, di;
  logic [7:0] s1, s2, s3;
  logic [2:0] lk;
  logic [1:0] drv, wrp;
  int num_errors = 0;
  int checked = 0;
  fsr_status_regs uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_DI(di), .I_WP_N(wp_n), .I_HOLD_RESET_N(hr_n),
    .I_ERASE_ACTIVE(er), .I_PROG_ACTIVE(pr), .O_DO(dout), .O_DO_OE(doe),
    .O_FIRST_STATUS(s1), .O_SECOND_STATUS(s2), .O_THIRD_STATUS(s3),
    .O_SECTOR_LOCKED(lk), .O_PAUSE(ps), .O_PIN_RESET(prst),
    .O_DRIVE(drv), .O_WRAP(wrp));
  fsr_spi_host host (.i_clk(clk), .i_do(dout), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_di(di));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // Write-status frame of n bits, optionally after a latch-set frame
  task automatic wr(input logic [31:0] d, input int n, input logic lat,
                    input logic ok);
    int k;
    k = 0;
    if (lat) host.frame({OP_WRITE_LATCH_SET, 24'h000000}, 8);
    host.frame(d, n);
    chk("busy", {15'h0, ok}, {15'h0, s1[0]});
    while (s1[0] === 1'b1 && k < 400) begin
      host.wait_clk(1);
      k++;
    end
    if (ok) chk("cycle", 16'h1,
      {15'h0, k > WRITE_CYCLES - 20 && k <= WRITE_CYCLES});
    chk("latch", {15'h0, lat && !ok}, {15'h0, s1[1]});
  endtask : wr
  task automatic rd3(input logic [7:0] op, input logic [7:0] e);
    host.frame({op, 24'h000000}, 24);
    chk("read3", {e, e}, host.rx);
    chk("oe", 16'h0, {15'h0, doe});
  endtask : rd3
  task automatic pins(input logic [1:0] e);
    hr_n = 1'b0;
    host.wait_clk(6);
    chk("pins", {14'h0, e}, {14'h0, ps, prst});
    hr_n = 1'b1;
    host.wait_clk(6);
  endtask : pins
  task automatic t_reset();
    chk("sr2", 16'h02, {8'h0, s2});
    chk("sr3", 16'h00, {8'h0, s3});
    pins(2'b00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_refuse();
    wr({OP_WRITE_STATUS, 24'h00FF00}, 32, 1'b0, 1'b0);
    wr({OP_WRITE_STATUS, 24'h00FD00}, 20, 1'b1, 1'b0);
    chk("sr2", 16'h02, {8'h0, s2});
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_write();
    wr({OP_WRITE_STATUS, 24'h3FFDFF}, 32, 1'b1, 1'b1);
    chk("sr1", 16'h3C, {8'h0, s1});
    chk("sr2", 16'h78, {8'h0, s2});
    chk("lock", 16'h7, {13'h0, lk});
    chk("sr3", 16'hF8, {8'h0, s3});
    rd3(OP_READ_THIRD_A, 8'hF8);
    wr({OP_WRITE_STATUS, 24'h000000}, 24, 1'b1, 1'b1);
    chk("sr2", 16'h78, {8'h0, s2 & 8'hFE});
    $display("write test done");
  endtask : t_write
  task automatic t_codes();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr({OP_WRITE_STATUS, 16'h0000, 1'b0, c, ~c, 3'h7}, 32, 1'b1, 1'b1);
      chk("code", {12'h0, c, ~c}, {12'h0, drv, wrp});
      chk("sr3", {8'h0, 1'b0, c, ~c, 3'h0}, {8'h0, s3});
    end
    $display("code test done");
  endtask : t_codes
  task automatic t_pin();
    pins(2'b10);
    wr({OP_WRITE_STATUS, 24'h000080}, 32, 1'b1, 1'b1);
    pins(2'b01);
    rd3(OP_READ_THIRD_B, 8'h80);
    $display("pin test done");
  endtask : t_pin
  task automatic t_hwlock();
    wr({OP_WRITE_STATUS, 24'h800080}, 32, 1'b1, 1'b1);
    wp_n = 1'b0;
    wr({OP_WRITE_STATUS, 24'h000000}, 32, 1'b1, 1'b0);
    chk("sr1", 16'h82, {8'h0, s1});
    wp_n = 1'b1;
    $display("hw lock test done");
  endtask : t_hwlock
  task automatic t_susp();
    host.frame({OP_SUSPEND, 24'h0}, 8);
    chk("idle", 16'h0, {8'h0, s2 & 8'h84});
    er = 1'b1;
    host.frame({OP_SUSPEND, 24'h0}, 8);
    chk("erase", 16'h1, {15'h0, s2[7]});
    rd3(OP_READ_THIRD_A, 8'h80);
    rd3(OP_READ_SECOND_B, 8'hF8);
    host.frame({OP_RESUME, 24'h0}, 8);
    chk("erase", 16'h0, {15'h0, s2[7]});
    er = 1'b0;
    pr = 1'b1;
    host.frame({OP_SUSPEND, 24'h0}, 8);
    chk("prog", 16'h1, {15'h0, s2[2]});
    host.frame({OP_RESUME, 24'h0}, 8);
    chk("prog", 16'h0, {15'h0, s2[2]});
    host.frame({OP_SUSPEND, 24'h0}, 8);
    chk("prog", 16'h1, {15'h0, s2[2]});
    rd3(OP_READ_STATUS, 8'h82);
    host.frame({OP_WRITE_LATCH_CLR, 24'h0}, 8);
    chk("latch", 16'h0, {15'h0, s1[1]});
    rst_n = 1'b0;
    host.wait_clk(3);
    rst_n = 1'b1;
    host.wait_clk(5);
    chk("susp", 16'h0, {8'h0, s2 & 8'h84});
    $display("suspend test done");
  endtask : t_susp
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Tests take about 7000 clocks; seven times that is allowed
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    er = 1'b0;
    pr = 1'b0;
    wp_n = 1'b1;
    hr_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.wait_clk(5);
    t_reset();
    t_refuse();
    t_write();
    t_codes();
    t_pin();
    t_hwlock();
    t_susp();
    print_verdict();
  end
endmodule : tb_fsr_status_regs
`default_nettype wire
